// [logic/lv_reset_function_defs.vh]
`ifndef LV_RESET_FUNCTION_DEFS_VH
`define LV_RESET_FUNCTION_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define LV_RESET_FUNCTION_ADDR_W        4
`define LV_RESET_FUNCTION_OFS_CTRL      4'h0
`define LV_RESET_FUNCTION_OFS_STAT      4'h1
`define LV_RESET_FUNCTION_OFS_IRQ_STAT  4'h2
`define LV_RESET_FUNCTION_OFS_IRQ_CLR   4'h3
`define LV_RESET_FUNCTION_OFS_IRQ_EN    4'h4
// ****************************************
// control fields
// ****************************************
`define LV_RESET_FUNCTION_CTRL_DE       7
`define LV_RESET_FUNCTION_CTRL_SEL      6
`define LV_RESET_FUNCTION_CTRL_RE       5
`define LV_RESET_FUNCTION_CTRL_FIE      1
`define LV_RESET_FUNCTION_CTRL_RIE      0
`define LV_RESET_FUNCTION_CTRL_MASK     8'hE3
`define LV_RESET_FUNCTION_CTRL_RST      8'h00
// ****************************************
// status fields
// ****************************************
`define LV_RESET_FUNCTION_STAT_FALL     1
`define LV_RESET_FUNCTION_STAT_RISE     0
`define LV_RESET_FUNCTION_STAT_RSVD     8'hFC
// ****************************************
// interrupt fields
// ****************************************
`define LV_RESET_FUNCTION_IRQ_FALL      0
`define LV_RESET_FUNCTION_IRQ_RISE      1
`define LV_RESET_FUNCTION_IRQ_RESET     2
`define LV_RESET_FUNCTION_IRQ_W         3
`define LV_RESET_FUNCTION_IRQ_ZERO      3'h0
// ****************************************
// reset release count
// ****************************************
`define LV_RESET_FUNCTION_RELEASE_CYC   18'h20000
`define LV_RESET_FUNCTION_CNT_W         18
`define LV_RESET_FUNCTION_CNT_ZERO      18'h00000
`define LV_RESET_FUNCTION_CNT_ONE       18'h00001
`endif

// [logic/lv_reset_function_sync2.v]
`timescale 1ns/10ps
module lv_reset_function_sync2 (
  // clock and reset
  input  wire clk,
  input  wire rstn,
  // level in and out
  input  wire d_in,
  output wire q_out
);
  reg meta_r;
  reg sync_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end
  assign q_out = sync_r;
endmodule // lv_reset_function_sync2

// [logic/lv_reset_function_prescaler.v]
`timescale 1ns/10ps
`include "lv_reset_function_defs.vh"
module lv_reset_function_prescaler #(
  parameter [17:0] RELEASE_CYC = `LV_RESET_FUNCTION_RELEASE_CYC
) (
  // clock and reset
  input  wire clk,
  input  wire rstn,
  // control
  input  wire hold,
  output wire done
);
  reg [`LV_RESET_FUNCTION_CNT_W-1:0] cnt_r;
  reg                   done_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= `LV_RESET_FUNCTION_CNT_ZERO;
      done_r <= 1'b1;
    end else if (hold) begin
      cnt_r  <= `LV_RESET_FUNCTION_CNT_ZERO;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (cnt_r == RELEASE_CYC - `LV_RESET_FUNCTION_CNT_ONE)
        done_r <= 1'b1;
      else
        cnt_r <= cnt_r + `LV_RESET_FUNCTION_CNT_ONE;
    end
  end
  assign done = done_r;
endmodule // lv_reset_function_prescaler

// [logic/lv_reset_function_top.v]
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
`include "lv_reset_function_defs.vh"
module lv_reset_function_top #(
  parameter [17:0] RELEASE_CYC = `LV_RESET_FUNCTION_RELEASE_CYC
) (
  // clock and power-on reset
  input  wire                    clk,
  input  wire                    rstn,
  // register port
  input  wire [`LV_RESET_FUNCTION_ADDR_W-1:0] addr,
  input  wire [7:0]              wdata,
  input  wire                    wr,
  input  wire                    rd,
  output wire [7:0]              rdata,
  // comparators, asynchronous
  input  wire                    below_fall,
  input  wire                    above_rise,
  input  wire                    below_reset,
  // outputs
  output wire                    lv_reset_n,
  output wire                    fall_irq,
  output wire                    rise_irq,
  output wire                    irq
);
  // ****************************************
  // synchronisers
  // ****************************************
  wire fall_s;
  wire rise_s;
  wire rst_s;
  lv_reset_function_sync2 u_sync_fall (
    .clk   (clk),
    .rstn  (rstn),
    .d_in  (below_fall),
    .q_out (fall_s)
  );
  lv_reset_function_sync2 u_sync_rise (
    .clk   (clk),
    .rstn  (rstn),
    .d_in  (above_rise),
    .q_out (rise_s)
  );
  lv_reset_function_sync2 u_sync_rst (
    .clk   (clk),
    .rstn  (rstn),
    .d_in  (below_reset),
    .q_out (rst_s)
  );
  // ****************************************
  // control and decode
  // ****************************************
  reg  [7:0] ctrl_r;
  reg        fall_flag_r;
  reg        rise_flag_r;
  reg        fall_seen_r;
  reg        rise_armed_r;
  reg        rd_fall_one_r;
  reg        rd_rise_one_r;
  reg  [`LV_RESET_FUNCTION_IRQ_W-1:0] irq_stat_r;
  reg  [`LV_RESET_FUNCTION_IRQ_W-1:0] irq_en_r;
  reg  [7:0] rdata_r;
  reg        lvr_active_r;
  function hit;
    input [`LV_RESET_FUNCTION_ADDR_W-1:0] a;
    input [`LV_RESET_FUNCTION_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction
  wire wr_ctrl  = wr & hit(addr, `LV_RESET_FUNCTION_OFS_CTRL);
  wire wr_stat  = wr & hit(addr, `LV_RESET_FUNCTION_OFS_STAT);
  wire wr_iclr  = wr & hit(addr, `LV_RESET_FUNCTION_OFS_IRQ_CLR);
  wire wr_ien   = wr & hit(addr, `LV_RESET_FUNCTION_OFS_IRQ_EN);
  wire rd_stat  = rd & hit(addr, `LV_RESET_FUNCTION_OFS_STAT);
  wire de       = ctrl_r[`LV_RESET_FUNCTION_CTRL_DE];
  // detection disabled masks every other control bit
  wire sel      = de & ctrl_r[`LV_RESET_FUNCTION_CTRL_SEL];
  wire re_en    = de & ctrl_r[`LV_RESET_FUNCTION_CTRL_RE];
  wire fie      = de & ~sel & ctrl_r[`LV_RESET_FUNCTION_CTRL_FIE];
  wire rie      = de & ~sel & ctrl_r[`LV_RESET_FUNCTION_CTRL_RIE];
  // ****************************************
  // low-voltage reset generation
  // ****************************************
  wire lv_hold = re_en & rst_s;
  wire pre_done;
  lv_reset_function_prescaler #(
    .RELEASE_CYC (RELEASE_CYC)
  ) u_pre (
    .clk  (clk),
    .rstn (rstn),
    .hold (lv_hold),
    .done (pre_done)
  );
  wire lv_rst = ~pre_done;
  assign lv_reset_n = pre_done;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      lvr_active_r <= 1'b0;
    else
      lvr_active_r <= lv_rst;
  end
  // ****************************************
  // control register
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      ctrl_r <= `LV_RESET_FUNCTION_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wdata & `LV_RESET_FUNCTION_CTRL_MASK;
  end
  // ****************************************
  // status flags
  // ****************************************
  wire fall_set = fie & fall_s & ~fall_seen_r;
  wire rise_set = rie & rise_armed_r & rise_s & ~rst_s;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fall_seen_r   <= 1'b0;
      rise_armed_r  <= 1'b0;
      fall_flag_r   <= 1'b0;
      rise_flag_r   <= 1'b0;
      rd_fall_one_r <= 1'b0;
      rd_rise_one_r <= 1'b0;
    end else if (lv_rst) begin
      fall_seen_r   <= 1'b0;
      rise_armed_r  <= 1'b0;
      fall_flag_r   <= 1'b0;
      rise_flag_r   <= 1'b0;
      rd_fall_one_r <= 1'b0;
      rd_rise_one_r <= 1'b0;
    end else begin
      fall_seen_r <= fall_s;
      // arm on fall, disarm at reset level or once risen
      if (rst_s | ~de)
        rise_armed_r <= 1'b0;
      else if (fall_s & rie)
        rise_armed_r <= 1'b1;
      else if (rise_set)
        rise_armed_r <= 1'b0;
      if (rd_stat) begin
        rd_fall_one_r <= fall_flag_r;
        rd_rise_one_r <= rise_flag_r;
      end
      // set wins over clear
      if (fall_set)
        fall_flag_r <= 1'b1;
      else if (wr_stat & rd_fall_one_r & ~wdata[`LV_RESET_FUNCTION_STAT_FALL]) begin
        fall_flag_r   <= 1'b0;
        rd_fall_one_r <= 1'b0;
      end
      if (rise_set)
        rise_flag_r <= 1'b1;
      else if (wr_stat & rd_rise_one_r & ~wdata[`LV_RESET_FUNCTION_STAT_RISE]) begin
        rise_flag_r   <= 1'b0;
        rd_rise_one_r <= 1'b0;
      end
    end
  end
  assign fall_irq = fall_flag_r & fie;
  assign rise_irq = rise_flag_r & rie;
  // ****************************************
  // interrupt status, clear, enable
  // ****************************************
  wire [`LV_RESET_FUNCTION_IRQ_W-1:0] ev;
  assign ev[`LV_RESET_FUNCTION_IRQ_FALL]  = fall_set;
  assign ev[`LV_RESET_FUNCTION_IRQ_RISE]  = rise_set;
  assign ev[`LV_RESET_FUNCTION_IRQ_RESET] = lv_rst & ~lvr_active_r;
  genvar gi;
  generate
    for (gi = 0; gi < `LV_RESET_FUNCTION_IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge clk or negedge rstn) begin
        if (!rstn)
          irq_stat_r[gi] <= 1'b0;
        else if (ev[gi])
          irq_stat_r[gi] <= 1'b1;
        else if (wr_iclr & wdata[gi])
          irq_stat_r[gi] <= 1'b0;
      end
    end
  endgenerate
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      irq_en_r <= `LV_RESET_FUNCTION_IRQ_ZERO;
    else if (wr_ien)
      irq_en_r <= wdata[`LV_RESET_FUNCTION_IRQ_W-1:0];
  end
  assign irq = |(irq_stat_r & irq_en_r);
  // ****************************************
  // read data, one cycle after strobe
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      rdata_r <= 8'h00;
    else if (rd) begin
      case (addr)
        `LV_RESET_FUNCTION_OFS_CTRL:
          rdata_r <= ctrl_r;
        `LV_RESET_FUNCTION_OFS_STAT:
          rdata_r <= `LV_RESET_FUNCTION_STAT_RSVD |
                     {6'h00, fall_flag_r, rise_flag_r};
        `LV_RESET_FUNCTION_OFS_IRQ_STAT:
          rdata_r <= {5'h00, irq_stat_r};
        `LV_RESET_FUNCTION_OFS_IRQ_EN:
          rdata_r <= {5'h00, irq_en_r};
        default:
          rdata_r <= 8'h00;
      endcase
    end else
      rdata_r <= 8'h00;
  end
  assign rdata = rdata_r;
  // software sequencing is the host's duty
endmodule // lv_reset_function_top

// [test/lv_reset_function_supply_model.sv]
`timescale 1ns/10ps
module lv_reset_function_supply_model #(
  parameter [15:0] FALL_MV  = 16'hE74,
  parameter [15:0] RISE_MV  = 16'hFA0,
  parameter [15:0] RESET_MV = 16'h8FC
) (
  // supply level, millivolts
  input  wire [15:0] vcc_mv,
  // comparator levels, settle off the edge
  output wire        below_fall,
  output wire        above_rise,
  output wire        below_reset
);
  assign #7 below_fall  = vcc_mv < FALL_MV;
  assign #7 above_rise  = vcc_mv > RISE_MV;
  assign #7 below_reset = vcc_mv < RESET_MV;
endmodule // lv_reset_function_supply_model

// [test/lv_reset_function_top_sva.sv]
`timescale 1ns/10ps
`include "lv_reset_function_defs.vh"
module lv_reset_function_top_sva #(
  parameter [17:0] RELEASE_CYC = `LV_RESET_FUNCTION_RELEASE_CYC
) (
  input wire       clk,
  input wire       rstn,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       below_fall,
  input wire       above_rise,
  input wire       below_reset,
  input wire       lv_reset_n,
  input wire       fall_irq,
  input wire       rise_irq,
  input wire       irq
);
  // ****
  // control shadow, quiet supply count
  // ****
  reg [7:0] ctl_r;
  int       quiet_r;
  wire      rst_en = ctl_r[7] & ctl_r[5];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r   <= 8'h00;
      quiet_r <= 0;
    end else begin
      if (wr && addr == `LV_RESET_FUNCTION_OFS_CTRL) ctl_r <= wdata & 8'hE3;
      if (below_reset) quiet_r <= 0;
      else if (quiet_r < RELEASE_CYC + 8) quiet_r <= quiet_r + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rsvd; rd && addr == 4'h1 |=> rdata[7:2] == 6'h3F; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_fie; fall_irq |-> ctl_r[7] && !ctl_r[6] && ctl_r[1]; endproperty
  a_fie: assert property (p_fie) else $error("fall irq");
  property p_rie; rise_irq |-> ctl_r[7] && !ctl_r[6] && ctl_r[0]; endproperty
  a_rie: assert property (p_rie) else $error("rise irq");
  property p_sync;
    $fell(lv_reset_n) |-> $past(rst_en) && $past(below_reset, 2)
      && $past(below_reset, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("early reset");
  property p_low; (below_reset && rst_en) [*4] |-> !lv_reset_n; endproperty
  a_low: assert property (p_low) else $error("no reset");
  property p_min; $rose(lv_reset_n) |-> quiet_r >= RELEASE_CYC; endproperty
  a_min: assert property (p_min) else $error("short release");
  property p_max; quiet_r > RELEASE_CYC + 6 |-> lv_reset_n; endproperty
  a_max: assert property (p_max) else $error("late release");
  property p_clr;
    !lv_reset_n && !$past(lv_reset_n) && rd && addr == 4'h1
      |=> rdata[1:0] == 2'b00;
  endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
  c_lv: cover property ($fell(lv_reset_n));
  c_rise: cover property ($rose(rise_irq));
  c_irq: cover property ($rose(irq));
endmodule // lv_reset_function_top_sva
bind lv_reset_function_top lv_reset_function_top_sva #(.RELEASE_CYC(RELEASE_CYC)) u_sva (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .below_fall(below_fall), .above_rise(above_rise),
  .below_reset(below_reset), .lv_reset_n(lv_reset_n),
  .fall_irq(fall_irq), .rise_irq(rise_irq), .irq(irq));

// [test/lv_reset_function_test.sv]
`timescale 1ns/10ps
module lv_reset_function_test;
  reg         clk, rstn, wr, rd, rd_d;
  reg  [3:0]  addr;
  reg  [7:0]  wdata;
  reg  [15:0] vcc;
  wire [7:0]  rdata;
  wire        bf, ar, br, lvn, fi, ri, irq;
  integer     failures, n_compared, seed;
  logic [7:0] exp_q[$];
  lv_reset_function_supply_model u_sup (.vcc_mv(vcc), .below_fall(bf),
    .above_rise(ar), .below_reset(br));
  lv_reset_function_top #(.RELEASE_CYC(18'h00010)) dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .below_fall(bf), .above_rise(ar), .below_reset(br), .lv_reset_n(lvn),
    .fall_irq(fi), .rise_irq(ri), .irq(irq));
  // ****
  // bus, compare and closing tasks
  // ****
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  // lv_reset_n, fall_irq, rise_irq
  task pins(input logic [2:0] e);
    @(posedge clk);
    chk("pins", {5'h00, lvn, fi, ri}, {5'h00, e});
  endtask
  task complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) chk("rdata", rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    {rstn, wr, rd, addr, wdata} = 15'h0000;
    vcc = 16'h1388;
    failures = 0;
    n_compared = 0;
    seed = 30510;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdx(4'h0, 8'h00);
    acc(1'b1, 4'h1, 8'($random(seed)));
    rdx(4'h1, 8'hFC);
    acc(1'b1, 4'h9, 8'($random(seed)));
    rdx(4'h9, 8'h00);
    acc(1'b1, 4'h0, 8'h23);
    vcc <= 16'h07D0;
    repeat (10) @(posedge clk);
    pins(3'h4);
    vcc <= 16'h1388;
    acc(1'b1, 4'h0, 8'h80);
    repeat (2000) @(posedge clk);
    acc(1'b1, 4'h0, 8'h83);
    acc(1'b1, 4'h4, 8'h00);
    vcc <= 16'h0BB8;
    repeat (8) @(posedge clk);
    pins(3'h6);
    acc(1'b1, 4'h1, 8'h00);
    rdx(4'h1, 8'hFE);
    rdx(4'h2, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    acc(1'b1, 4'h4, 8'h01);
    @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    acc(1'b1, 4'h3, 8'h01);
    acc(1'b1, 4'h1, 8'h00);
    rdx(4'h1, 8'hFC);
    chk("irq", {7'h00, irq}, 8'h00);
    vcc <= 16'h1194;
    repeat (8) @(posedge clk);
    rdx(4'h1, 8'hFD);
    pins(3'h5);
    acc(1'b1, 4'h0, 8'hA3);
    vcc <= 16'h07D0;
    repeat (6) @(posedge clk);
    rdx(4'h1, 8'hFC);
    vcc <= 16'h1388;
    repeat (12) @(posedge clk);
    pins(3'h0);
    repeat (12) @(posedge clk);
    pins(3'h4);
    rdx(4'h0, 8'hA3);
    acc(1'b1, 4'h0, 8'hE3);
    vcc <= 16'h0BB8;
    repeat (8) @(posedge clk);
    pins(3'h4);
    vcc <= 16'h1388;
    acc(1'b1, 4'h0, 8'hC3);
    acc(1'b1, 4'h0, 8'h00);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdx(4'h0, 8'h00);
    repeat (2) @(posedge clk);
    complete_run;
  end
endmodule // lv_reset_function_test
